//--- core/dscp_serial_port.sv
// serial register access port with buffered update
//
// Overview of operation
// - instruction phase then register data phase
// - instruction bit 7 high means read
// - instruction bit 6 is ignored
// - low six instruction bits give address
// - data bytes equal register byte width
// - sample data on rising serial clock
// - resync high aborts, resets byte pointer
// - abort keeps full bytes, drops partial
// - next eight rising edges form instruction
// - writes stay buffered until update strobe
// - profile select change also updates
// - update on rising edge, sync clock timed
// - reads return active registers, falling edge
// - select high tristates both data lines
// - select high suspends, low resumes
// - sdio also drives read data unless cfg bit 1 selects input only
// - two wire mode keeps output pin off
// - bit 0 selects lsb first everywhere
// - highest numbered bit is register msb
// - no clock pause needed after instruction
`timescale 1ns/1ps
`default_nettype none
module dscp_serial_port
	import dscp_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_sys_rst,
	input  wire logic                      i_sclk,
	input  wire logic                      i_cs_n,
	input  wire logic                      i_port_resync_abort,
	input  wire logic                      i_sdio,
	input  wire logic                      i_io_update,
	input  wire logic                      i_sync_clk,
	input  wire logic [dscp_pkg::PS_W-1:0] i_profile_select_inputs,
	output logic                           o_sdio,
	output logic                           o_sdio_oe,
	output logic                           o_serial_data_output_pin,
	output logic                           o_serial_data_output_pin_oe,
	output logic                           o_update_done,
	output logic                           o_lsb_first,
	output logic                           o_sdio_input_only
);
	import dscp_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [BYTE_SEL_W-1:0] byte_idx(
		input logic [BYTE_SEL_W-1:0] cnt,
		input logic                  lsb
	);
		byte_idx = lsb ? cnt : ~cnt;
	endfunction

	function automatic logic [BIT_POS_W-1:0] bit_pos(
		input logic [BYTE_SEL_W-1:0] byte_cnt,
		input logic [BIT_SEL_W-1:0]  bit_cnt,
		input logic                  lsb
	);
		bit_pos = {byte_idx(byte_cnt, lsb), (lsb ? bit_cnt : ~bit_cnt)};
	endfunction

	typedef struct packed {
		logic [SY_W-1:0]       sy1;
		logic [SY_W-1:0]       sy2;
		logic [SY_W-1:0]       sy3;
		dscp_state_t           st;
		logic [BIT_SEL_W-1:0]  bit_cnt;
		logic [BYTE_SEL_W-1:0] byte_cnt;
		logic [BYTE_W-1:0]     sh;
		logic [REG_AW-1:0]     addr;
		logic                  wr_en;
		logic [BYTE_SEL_W-1:0] wr_byte;
		logic [BYTE_W-1:0]     wr_data;
		logic                  out_bit;
		logic                  sdio_oe;
		logic                  sdo_oe;
		logic                  pend;
		logic                  upd;
	} dscp_port_t;

	dscp_port_t                q_ff;
	dscp_port_t                nxt_q;
	logic [REG_W-1:0]          rd_data;
	logic [CFG_W-1:0]          cfg;
	logic                      lsb;
	logic                      in_only;
	logic                      sclk_rise;
	logic                      sclk_fall;
	logic                      sel;
	logic                      resync;
	logic                      din;
	logic                      io_rise;
	logic                      ps_chg;
	logic                      sync_rise;
	logic [BYTE_W-1:0]         nb;

	// ****************************************
	// decoded synchronised inputs
	// ****************************************
	assign lsb       = cfg[CFG_LSB_FIRST_BIT];
	assign in_only   = cfg[CFG_SDIO_IN_ONLY_BIT];
	assign sclk_rise = q_ff.sy2[SY_SCLK] & ~q_ff.sy3[SY_SCLK];
	assign sclk_fall = ~q_ff.sy2[SY_SCLK] & q_ff.sy3[SY_SCLK];
	assign sel       = ~q_ff.sy2[SY_CS_N];
	assign resync    = q_ff.sy2[SY_RSY];
	assign din       = q_ff.sy2[SY_SDI];
	assign io_rise   = q_ff.sy2[SY_IOU] & ~q_ff.sy3[SY_IOU];
	assign ps_chg    = q_ff.sy2[SY_PS_HI:SY_PS_LO] != q_ff.sy3[SY_PS_HI:SY_PS_LO];
	assign sync_rise = q_ff.sy2[SY_SYNC] & ~q_ff.sy3[SY_SYNC];
	assign nb = lsb ? {din, q_ff.sh[BYTE_W-1:1]} : {q_ff.sh[BYTE_W-2:0], din};

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		nxt_q       = q_ff;
		nxt_q.sy1   = {i_profile_select_inputs, i_sync_clk, i_io_update, i_sdio,
			i_port_resync_abort, i_cs_n, i_sclk};
		nxt_q.sy2   = q_ff.sy1;
		nxt_q.sy3   = q_ff.sy2;
		nxt_q.wr_en = 1'b0;
		nxt_q.upd   = 1'b0;
		if (resync)
		begin
			nxt_q.st       = DSCP_ST_INSTR;
			nxt_q.bit_cnt  = BIT_FIRST;
			nxt_q.byte_cnt = BYTE_FIRST;
		end
		else if (sel && sclk_rise)
		begin
			nxt_q.sh      = nb;
			nxt_q.bit_cnt = q_ff.bit_cnt + BIT_STEP;
			if (q_ff.bit_cnt == LAST_BIT)
			begin
				case (q_ff.st)
					DSCP_ST_INSTR:
					begin
						nxt_q.addr     = nb[INSTR_ADDR_MSB:0];
						nxt_q.st       = nb[INSTR_RD_BIT] ? DSCP_ST_RD : DSCP_ST_WR;
						nxt_q.byte_cnt = BYTE_FIRST;
					end
					DSCP_ST_WR, DSCP_ST_RD:
					begin
						if (q_ff.st == DSCP_ST_WR)
						begin
							nxt_q.wr_en   = 1'b1;
							nxt_q.wr_byte = byte_idx(q_ff.byte_cnt, lsb);
							nxt_q.wr_data = nb;
						end
						nxt_q.byte_cnt = q_ff.byte_cnt + BYTE_STEP;
						if (q_ff.byte_cnt == LAST_BYTE)
						begin
							nxt_q.st = DSCP_ST_INSTR;
						end
					end
					default:
					begin
						nxt_q.st = DSCP_ST_INSTR;
					end
				endcase
			end
		end
		if (sel && sclk_fall && q_ff.st == DSCP_ST_RD)
		begin
			nxt_q.out_bit = rd_data[bit_pos(q_ff.byte_cnt, q_ff.bit_cnt, lsb)];
		end
		// sdo off in two wire mode
		nxt_q.sdio_oe = sel && !resync && q_ff.st == DSCP_ST_RD && !in_only;
		nxt_q.sdo_oe  = sel && !resync && q_ff.st == DSCP_ST_RD && in_only;
		if (q_ff.pend && sync_rise)
		begin
			nxt_q.upd  = 1'b1;
			nxt_q.pend = 1'b0;
		end
		if (io_rise || ps_chg)
		begin
			nxt_q.pend = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			q_ff <= '0;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	// ****************************************
	// register arrays
	// ****************************************
	dscp_reg_mem dscp_reg_mem_i (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_wr_en    (q_ff.wr_en),
		.i_wr_addr  (q_ff.addr),
		.i_wr_byte  (q_ff.wr_byte),
		.i_wr_data  (q_ff.wr_data),
		.i_update   (q_ff.upd),
		.i_rd_addr  (q_ff.addr),
		.o_rd_data  (rd_data),
		.o_cfg      (cfg)
	);

	assign o_sdio                      = q_ff.out_bit;
	assign o_sdio_oe                   = q_ff.sdio_oe;
	assign o_serial_data_output_pin    = q_ff.out_bit;
	assign o_serial_data_output_pin_oe = q_ff.sdo_oe;
	assign o_update_done               = q_ff.upd;
	assign o_lsb_first                 = lsb;
	assign o_sdio_input_only           = in_only;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	logic instr_done;
	logic last_data;
	assign instr_done = !resync && sel && sclk_rise && q_ff.bit_cnt == LAST_BIT
		&& q_ff.st == DSCP_ST_INSTR;
	assign last_data  = !resync && sel && sclk_rise && q_ff.bit_cnt == LAST_BIT
		&& q_ff.byte_cnt == LAST_BYTE && q_ff.st != DSCP_ST_INSTR;

	AST_DIR_DECODE: assert property (instr_done |=>
		q_ff.st == ($past(nb[INSTR_RD_BIT]) ? DSCP_ST_RD : DSCP_ST_WR))
		else $error("direction decode wrong");
	AST_ADDR_CAPTURE: assert property (instr_done |=>
		q_ff.addr == $past(nb[INSTR_ADDR_MSB:0]) && q_ff.byte_cnt == BYTE_FIRST)
		else $error("address not captured");
	AST_RESYNC_ABORT: assert property (resync |=>
		q_ff.st == DSCP_ST_INSTR && q_ff.bit_cnt == BIT_FIRST && !q_ff.wr_en)
		else $error("resync did not abort");
	AST_TRANS_END: assert property (last_data |=> q_ff.st == DSCP_ST_INSTR)
		else $error("no return to instruction phase");
	AST_WRITE_BYTE: assert property (last_data && q_ff.st == DSCP_ST_WR |=>
		q_ff.wr_en && q_ff.wr_data == $past(nb))
		else $error("write byte lost");
	AST_CS_TRISTATE: assert property (!sel |=> !o_sdio_oe && !o_serial_data_output_pin_oe)
		else $error("data line driven while deselected");
	// sdo quiet in two wire mode
	AST_SDO_QUIET: assert property ((!in_only)[*2] |-> !o_serial_data_output_pin_oe)
		else $error("output pin driven in two wire mode");
	AST_SUSPEND: assert property (!sel && !resync |=>
		$stable(q_ff.st) && $stable(q_ff.bit_cnt) && $stable(q_ff.byte_cnt))
		else $error("transaction moved while deselected");
	AST_UPDATE_SYNC: assert property (o_update_done |-> $past(sync_rise) && $past(q_ff.pend))
		else $error("update without sync clock edge");
	AST_PROFILE_UPD: assert property (ps_chg |=> q_ff.pend)
		else $error("profile change ignored");
	// read data moves on falling edge
	AST_RD_FALL: assert property ($changed(o_sdio) |-> $past(sclk_fall))
		else $error("read bit changed off falling edge");
	AST_RD_SDIO_OE: assert property (q_ff.st == DSCP_ST_RD && sel && !resync
		&& !in_only |=> o_sdio_oe)
		else $error("sdio not driven in read phase");
	AST_RD_SDO_OE: assert property (q_ff.st == DSCP_ST_RD && sel && !resync
		&& in_only |=> o_serial_data_output_pin_oe)
		else $error("output pin not driven in three wire read");
	AST_OE_EXCLUSIVE: assert property (!(o_sdio_oe && o_serial_data_output_pin_oe))
		else $error("both data lines driven");
	AST_WR_IN_WR: assert property (q_ff.wr_en |->
		$past(q_ff.st) == DSCP_ST_WR)
		else $error("buffer written outside write phase");
	AST_BIT_ON_RISE: assert property ($changed(q_ff.bit_cnt) |->
		$past(sclk_rise) || $past(resync))
		else $error("bit counter moved without clock edge");
	AST_PEND_SOURCE: assert property ($rose(q_ff.pend) |->
		$past(io_rise) || $past(ps_chg))
		else $error("update requested without cause");
	AST_IO_UPD_PEND: assert property (io_rise |=> q_ff.pend)
		else $error("update strobe ignored");
	AST_BYTE_PTR: assert property ($changed(q_ff.byte_cnt) |->
		$past(q_ff.bit_cnt) == LAST_BIT || $past(resync))
		else $error("byte pointer moved mid byte");
	AST_ADDR_HOLD: assert property ($changed(q_ff.addr) |->
		$past(instr_done))
		else $error("address changed outside instruction");
	AST_SUSPEND_NO_WR: assert property (!sel |=> !q_ff.wr_en)
		else $error("buffer written while deselected");
	AST_UPD_PULSE: assert property (o_update_done |=> !o_update_done)
		else $error("update pulse too long");
	// read bit only in read phase
	AST_RD_ONLY: assert property ($changed(o_sdio) |-> $past(q_ff.st) == DSCP_ST_RD)
		else $error("read bit changed outside read phase");

	COV_WRITE: cover property (last_data && q_ff.st == DSCP_ST_WR);
	COV_READ: cover property (last_data && q_ff.st == DSCP_ST_RD);
	COV_ABORT: cover property (resync && q_ff.st == DSCP_ST_WR);
	COV_UPDATE: cover property (o_update_done);
	COV_THREE_WIRE: cover property (o_serial_data_output_pin_oe);

endmodule
`default_nettype wire

//--- core/dscp_pkg.sv
// constants and types shared by the serial control port files
package dscp_pkg;

	// ****************************************
	// register array geometry
	// ****************************************
	localparam int          REG_AW      = 6;
	localparam int          NUM_REGS    = 64;
	localparam int          BYTE_W      = 8;
	localparam int          REG_W       = 32;
	localparam int          BYTE_SEL_W  = 2;
	localparam int          BIT_SEL_W   = 3;
	localparam int          BIT_POS_W   = 5;
	localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;

	// ****************************************
	// first control register fields
	// ****************************************
	localparam logic [REG_AW-1:0] FIRST_CTRL_ADDR = 6'h00;
	localparam int          CFG_LSB_FIRST_BIT    = 0;
	localparam int          CFG_SDIO_IN_ONLY_BIT = 1;
	localparam int          CFG_W                = 2;

	// ****************************************
	// instruction byte fields
	// ****************************************
	localparam int          INSTR_RD_BIT   = 7;
	localparam int          INSTR_ADDR_MSB = 5;

	// ****************************************
	// serial counters
	// ****************************************
	localparam logic [BIT_SEL_W-1:0]  LAST_BIT  = 3'h7;
	localparam logic [BIT_SEL_W-1:0]  BIT_STEP  = 3'h1;
	localparam logic [BIT_SEL_W-1:0]  BIT_FIRST = 3'h0;
	localparam logic [BYTE_SEL_W-1:0] LAST_BYTE = 2'h3;
	localparam logic [BYTE_SEL_W-1:0] BYTE_STEP = 2'h1;
	localparam logic [BYTE_SEL_W-1:0] BYTE_FIRST = 2'h0;

	// ****************************************
	// synchroniser bit positions
	// ****************************************
	localparam int          SY_W    = 9;
	localparam int          SY_SCLK = 0;
	localparam int          SY_CS_N = 1;
	localparam int          SY_RSY  = 2;
	localparam int          SY_SDI  = 3;
	localparam int          SY_IOU  = 4;
	localparam int          SY_SYNC = 5;
	localparam int          SY_PS_LO = 6;
	localparam int          SY_PS_HI = 8;
	localparam int          PS_W    = 3;

	typedef enum logic [1:0] {
		DSCP_ST_INSTR = 2'b00,
		DSCP_ST_WR    = 2'b01,
		DSCP_ST_RD    = 2'b10
	} dscp_state_t;

endpackage

//--- core/dscp_reg_mem.sv
// buffer and active register arrays of the serial control port
`timescale 1ns/1ps
`default_nettype none
module dscp_reg_mem
	import dscp_pkg::*;
(
	input  wire logic                          i_core_clk,
	input  wire logic                          i_sys_rst,
	input  wire logic                          i_wr_en,
	input  wire logic [dscp_pkg::REG_AW-1:0]     i_wr_addr,
	input  wire logic [dscp_pkg::BYTE_SEL_W-1:0] i_wr_byte,
	input  wire logic [dscp_pkg::BYTE_W-1:0]     i_wr_data,
	input  wire logic                          i_update,
	input  wire logic [dscp_pkg::REG_AW-1:0]     i_rd_addr,
	output logic      [dscp_pkg::REG_W-1:0]      o_rd_data,
	output logic      [dscp_pkg::CFG_W-1:0]      o_cfg
);
	import dscp_pkg::*;

	typedef struct packed {
		logic [NUM_REGS-1:0][REG_W-1:0] buffer;
		logic [NUM_REGS-1:0][REG_W-1:0] active;
		logic [REG_W-1:0]               rd_data;
		logic [CFG_W-1:0]               cfg;
	} dscp_mem_t;

	dscp_mem_t q;
	dscp_mem_t nxt_q;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		nxt_q = q;
		if (i_wr_en)
		begin
			nxt_q.buffer[i_wr_addr][{i_wr_byte, BIT_FIRST} +: BYTE_W] = i_wr_data;
		end
		if (i_update)
		begin
			nxt_q.active = q.buffer;
		end
		nxt_q.rd_data = q.active[i_rd_addr];
		nxt_q.cfg     = q.active[FIRST_CTRL_ADDR][CFG_W-1:0];
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= nxt_q;
		end
	end

	assign o_rd_data = q.rd_data;
	assign o_cfg     = q.cfg;

endmodule
`default_nettype wire

//--- dv/dscp_host_model.sv
// host controller model for the serial control port
`timescale 1ns/1ps
`default_nettype none
module dscp_host_model (
	input  wire logic        i_line,
	input  wire logic        i_oth_oe,
	output logic             o_sclk,
	output logic             o_cs_n,
	output logic             o_resync,
	output logic             o_sdio,
	output logic             o_sdio_oe,
	output logic             o_rd_valid,
	output logic [31:0]      o_rd_data,
	output logic             o_oth_seen
);
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_resync = 1'b0;
		o_sdio = 1'b0;
		o_sdio_oe = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_data = '0;
		o_oth_seen = 1'b0;
	end
	task automatic sel(input logic v);
		o_cs_n = v;
		#80;
	endtask
	task automatic send_bits(input logic [31:0] v, input int n, input logic lsb);
		for (int k = 0; k < n; k++)
		begin
			o_sdio_oe = 1'b1;
			o_sdio = lsb ? v[k] : v[n-1-k];
			o_sclk = 1'b0;
			#80;
			o_sclk = 1'b1;
			#80;
		end
	endtask
	task automatic recv_word(input logic lsb);
		logic [31:0] v;
		v = '0;
		o_sdio_oe = 1'b0;
		o_oth_seen = 1'b0;
		for (int k = 0; k < 32; k++)
		begin
			o_sclk = 1'b0;
			#80;
			v = lsb ? {i_line, v[31:1]} : {v[30:0], i_line};
			o_oth_seen = o_oth_seen | i_oth_oe;
			o_sclk = 1'b1;
			#80;
		end
		o_rd_data = v;
		#1;
		o_rd_valid = 1'b1;
		#7;
		o_rd_valid = 1'b0;
	endtask
	task automatic xact(input logic [7:0] ins, input logic [31:0] d, input logic lsb);
		sel(1'b0);
		send_bits({24'h0, ins}, 8, lsb);
		if (ins[7])
			recv_word(lsb);
		else
			send_bits(d, 32, lsb);
		sel(1'b1);
	endtask
	task automatic abort();
		o_resync = 1'b1;
		#160;
		o_resync = 1'b0;
		#160;
	endtask
	task automatic suspend();
		o_cs_n = 1'b1;
		repeat (3)
		begin
			o_sdio = ~o_sdio;
			o_sclk = 1'b0;
			#80;
			o_sclk = 1'b1;
			#80;
		end
		o_cs_n = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

//--- dv/dscp_serial_port_test.sv
// self-checking bench of the serial control port
`timescale 1ns/1ps
`default_nettype none
module dscp_serial_port_test;
	import dscp_pkg::*;
	logic              clk, rst, sync_clk, io_upd, pat, mode3;
	logic [PS_W-1:0]   ps;
	logic [31:0]       seed, d1, d2, d3, exp_q[$];
	int                n_mismatch, comparisons, cyc;
	wire logic         sclk, cs_n, rsy, h_d, h_oe, rd_v, oth;
	wire logic [31:0]  rd_d;
	wire logic         q_sdio, q_sdio_oe, q_sdo, q_sdo_oe, done, lsb, ionly;
	wire logic         sdio_w = q_sdio_oe ? q_sdio : (h_oe ? h_d : pat);
	wire logic         sdo_w = q_sdo_oe ? q_sdo : pat;
	dscp_serial_port dscp_serial_port_i (.i_core_clk(clk), .i_sys_rst(rst), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_port_resync_abort(rsy), .i_sdio(sdio_w), .i_io_update(io_upd),
		.i_sync_clk(sync_clk), .i_profile_select_inputs(ps), .o_sdio(q_sdio),
		.o_sdio_oe(q_sdio_oe), .o_serial_data_output_pin(q_sdo),
		.o_serial_data_output_pin_oe(q_sdo_oe), .o_update_done(done), .o_lsb_first(lsb),
		.o_sdio_input_only(ionly));
	dscp_host_model dscp_host_model_i (.i_line(mode3 ? sdo_w : sdio_w),
		.i_oth_oe(mode3 ? q_sdio_oe : q_sdo_oe), .o_sclk(sclk), .o_cs_n(cs_n),
		.o_resync(rsy), .o_sdio(h_d), .o_sdio_oe(h_oe), .o_rd_valid(rd_v),
		.o_rd_data(rd_d), .o_oth_seen(oth));
	// ****************************************
	// clocks, helpers and monitor
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		sync_clk = 1'b0;
		forever #32 sync_clk = ~sync_clk;
	end
	always @(posedge clk) pat <= rst ? 1'b0 : ~pat;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	always @(posedge rd_v) check("read word", rd_d, exp_q.pop_front());
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic lo);
		logic [31:0] r;
		r = rnd();
		dscp_host_model_i.xact({1'b0, r[0], a}, d, lo);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic lo);
		logic [31:0] r;
		r = rnd();
		exp_q.push_back(e);
		dscp_host_model_i.xact({1'b1, r[0], a}, 32'h0, lo);
	endtask
	task automatic update(input logic by_ps);
		int w;
		@(posedge clk) #1;
		if (by_ps)
			ps = ps + 3'h1;
		else
			io_upd = 1'b1;
		w = 0;
		while (done !== 1'b1 && w < 100)
		begin
			@(posedge clk) #1;
			w++;
		end
		check("update done", done, 1'b1);
		repeat (12) @(posedge clk) #1;
		io_upd = 1'b0;
		repeat (6) @(posedge clk) #1;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		seed = 32'h13;
		io_upd = 1'b0;
		ps = 3'h0;
		mode3 = 1'b0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		repeat (6) @(posedge clk) #1;
		check("reset cfg", {lsb, ionly, q_sdio_oe, q_sdo_oe}, 4'h0);
		d1 = rnd();
		wr(6'h05, d1, 1'b0);
		rd(6'h05, 32'h0, 1'b0);
		update(1'b0);
		rd(6'h05, d1, 1'b0);
		check("sdo oe in two wire", oth, 1'b0);
		repeat (4) @(posedge clk) #1;
		check("sdio oe deselected", q_sdio_oe, 1'b0);
		d2 = rnd();
		dscp_host_model_i.sel(1'b0);
		dscp_host_model_i.send_bits({24'h0, 8'h06}, 8, 1'b0);
		dscp_host_model_i.send_bits({16'h0, d2[31:16]}, 16, 1'b0);
		dscp_host_model_i.send_bits(32'h5, 3, 1'b0);
		dscp_host_model_i.abort();
		dscp_host_model_i.sel(1'b1);
		update(1'b0);
		rd(6'h06, {d2[31:16], 16'h0}, 1'b0);
		d3 = rnd();
		dscp_host_model_i.sel(1'b0);
		dscp_host_model_i.send_bits({24'h0, 8'h47}, 8, 1'b0);
		dscp_host_model_i.send_bits({24'h0, d3[31:24]}, 8, 1'b0);
		dscp_host_model_i.suspend();
		dscp_host_model_i.send_bits({8'h0, d3[23:0]}, 24, 1'b0);
		dscp_host_model_i.sel(1'b1);
		update(1'b1);
		rd(6'h07, d3, 1'b0);
		wr(FIRST_CTRL_ADDR, 32'h3, 1'b0);
		check("mode before update", {lsb, ionly}, 2'h0);
		update(1'b0);
		check("mode after update", {lsb, ionly}, 2'h3);
		mode3 = 1'b1;
		rd(6'h05, d1, 1'b1);
		check("sdio oe in three wire", oth, 1'b0);
		d3 = rnd();
		wr(6'h3f, d3, 1'b1);
		update(1'b1);
		rd(6'h3f, d3, 1'b1);
		d2 = rnd();
		wr(6'h15, d2, 1'b1);
		while (ps != 3'h5)
			update(1'b1);
		rd(6'h15, d2, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
